// ---- shared/sleep_wake_pkg.sv ----
// package: register map, field layout and state encoding of the sleep/wake controller
// assumes: one 100 MHz clock, AHB-Lite register access, 32-bit words
package sleep_wake_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_RISE_EN   = 12'h000;
  localparam logic [11:0] OFF_FALL_EN   = 12'h004;
  localparam logic [11:0] OFF_FLAGS     = 12'h008;
  localparam logic [11:0] OFF_STATUS    = 12'h00C;
  localparam logic [11:0] OFF_IRQ_EN    = 12'h010;
  localparam logic [11:0] OFF_CONTROL   = 12'h014;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int          PIN_COUNT       = 6;
  localparam logic [7:0]  EDGE_RESET      = 8'h00;
  localparam int          ST_POWER_DOWN   = 0;
  localparam int          ST_WDOG_EXPIRY  = 1;
  localparam int          ST_ASLEEP       = 2;
  localparam int          ST_SUMMARY      = 3;
  localparam int          CTL_WDOG_SLEEP  = 0;
  localparam logic [1:0]  STATUS_RESET    = 2'h3;
  localparam logic [7:0]  IRQ_EN_RESET    = 8'h00;
  localparam logic        CTL_RESET       = 1'b0;
  localparam int          WDOG_WIDTH      = 16;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ      = 2'h3;

  // ----------------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PS_RUN   = 2'b01,
    PS_SLEEP = 2'b10
  } power_state_t;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic ext_reset_pin;
    logic brownout_reset;
    logic power_on_reset;
    logic watchdog_wake;
  } reset_src_t;

endpackage

// ---- src/sleep_wake_control.sv ----
// sleep_wake_control: power-down entry, wake, watchdog clear and pin edge detection
// assumes: core pulses i_power_down_exec once per power-down instruction; AHB-Lite slave
//
// Behaviour
// - sleep entered only on execution of the power-down instruction
// - entry clears watchdog counter; keeps counting if enabled for sleep
// - entry clears power-down flag and sets watchdog-expiry flag
// - cpu clock gated off while asleep
// - low-frequency oscillator stays enabled while asleep
// - timer1 keeps running asleep when fed by low_freq_osc or ext pin
// - adc keeps running asleep when its dedicated oscillator is chosen
// - pin drive states held unchanged through sleep
// - non-watchdog reset sources remain active during sleep
// - resets wake by reset; watchdog and interrupts wake by resuming
// - next instruction is prefetched during the power-down instruction
// - interrupt wakes only if individually enabled, regardless of global gate
// - after wake run prefetched instruction, then vector if global gate set
// - watchdog counter cleared on every wake
// - enabled pending interrupt before instruction makes it a no_operation
// - interrupt during instruction: complete it, wake at once, update flags (code: an irq in the exec cycle gives no_operation, flags kept)
// - enabled rising edge sets pin change flag and summary flag
// - enabled falling edge sets pin change flag and summary flag
// - change flags sticky until software write clears; bits 7-6 read zero
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
module sleep_wake_control #(
  parameter int PINS = sleep_wake_pkg::PIN_COUNT,
  parameter int IRQS = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // ahb-lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic      [31:0]       o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // core side
  input  wire logic              i_power_down_exec,
  input  wire logic              i_global_irq_gate,
  input  wire logic [IRQS-1:0]   i_irq_flags,
  input  wire logic              i_timer1_on_slow_clk,
  input  wire logic              i_adc_on_dedicated_osc,
  input  wire logic              i_wdog_enable,
  input  wire logic              i_ext_reset_pin_enable,
  input  wire logic              i_brownout_enable,
  input  wire logic              i_ext_reset_pin_n,
  input  wire logic              i_brownout_reset,
  input  wire logic              i_power_on_reset,
  input  wire logic [PINS-1:0]   i_pins,
  output logic                   o_cpu_clk_en,
  output logic                   o_low_freq_osc_en,
  output logic                   o_timer1_run,
  output logic                   o_adc_run,
  output logic                   o_pin_hold,
  output logic                   o_prefetch_next,
  output logic                   o_resume,
  output logic                   o_vector_irq,
  output logic                   o_device_reset,
  output logic                   o_change_irq_summary,
  output logic [sleep_wake_pkg::WDOG_WIDTH-1:0] o_watchdog_counter
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  sleep_wake_pkg::power_state_t state;
  sleep_wake_pkg::bus_req_t     req;
  logic [PINS-1:0]              rise_wake_enable;
  logic [PINS-1:0]              fall_wake_enable;
  logic [PINS-1:0]              edge_change_flags;
  logic [IRQS-1:0]              irq_enable;
  logic                         power_down_flag;
  logic                         watchdog_expiry_flag;
  logic                         wdog_sleep_en;
  logic [PINS-1:0]              sync1;
  logic [PINS-1:0]              sync2;
  logic [PINS-1:0]              sync3;
  logic [PINS-1:0]              pin_level;
  logic [PINS-1:0]              rise_hit;
  logic [PINS-1:0]              fall_hit;
  logic [PINS-1:0]              flag_clear;
  logic [PINS-1:0]              next_flags;
  logic                         irq_wake;
  logic                         reset_wake;
  logic                         wdog_wake;
  logic                         enter_sleep;
  logic                         nop_sleep;
  logic                         wake_now;
  logic                         wr_data;
  logic [31:0]                  rd_mux;
  logic                         wdog_clear;

  function automatic logic [31:0] pad(input logic [PINS-1:0] v);
    pad = 32'h0000_0000;
    pad[PINS-1:0] = v;
  endfunction

  // ----------------------------------------------------------------------
  // pin synchroniser and edge detect
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= i_pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // a level counts once the second and third stage agree
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_level <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (sync2[i] == sync3[i]) begin
          pin_level[i] <= sync3[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      rise_hit[i] = (sync2[i] == sync3[i]) && sync3[i] && !pin_level[i];
      fall_hit[i] = (sync2[i] == sync3[i]) && !sync3[i] && pin_level[i];
    end
  end

  // ----------------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      req <= '0;
    end else if (i_hready) begin
      req.sel   <= i_hsel && (i_htrans == sleep_wake_pkg::HTRANS_NONSEQ ||
                              i_htrans == sleep_wake_pkg::HTRANS_SEQ);
      req.write <= i_hwrite;
      req.addr  <= i_haddr[11:0];
    end else begin
      req.sel <= 1'b0;
    end
  end

  assign wr_data     = req.sel && req.write;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_haddr[11:0])
      sleep_wake_pkg::OFF_RISE_EN: rd_mux = pad(rise_wake_enable);
      sleep_wake_pkg::OFF_FALL_EN: rd_mux = pad(fall_wake_enable);
      sleep_wake_pkg::OFF_FLAGS:   rd_mux = pad(edge_change_flags);
      sleep_wake_pkg::OFF_STATUS: begin
        rd_mux[sleep_wake_pkg::ST_POWER_DOWN]  = power_down_flag;
        rd_mux[sleep_wake_pkg::ST_WDOG_EXPIRY] = watchdog_expiry_flag;
        rd_mux[sleep_wake_pkg::ST_ASLEEP]      = (state == sleep_wake_pkg::PS_SLEEP);
        rd_mux[sleep_wake_pkg::ST_SUMMARY]     = o_change_irq_summary;
      end
      sleep_wake_pkg::OFF_IRQ_EN:  rd_mux[IRQS-1:0] = irq_enable;
      sleep_wake_pkg::OFF_CONTROL: rd_mux[sleep_wake_pkg::CTL_WDOG_SLEEP] = wdog_sleep_en;
      default:                     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
      // loaded in the address phase, stands through the data phase
      o_hrdata <= rd_mux;
    end else begin
      o_hrdata <= o_hrdata;
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rise_wake_enable <= sleep_wake_pkg::EDGE_RESET[PINS-1:0];
      fall_wake_enable <= sleep_wake_pkg::EDGE_RESET[PINS-1:0];
      irq_enable       <= sleep_wake_pkg::IRQ_EN_RESET[IRQS-1:0];
      wdog_sleep_en    <= sleep_wake_pkg::CTL_RESET;
    end else if (wr_data) begin
      case (req.addr)
        sleep_wake_pkg::OFF_RISE_EN: rise_wake_enable <= i_hwdata[PINS-1:0];
        sleep_wake_pkg::OFF_FALL_EN: fall_wake_enable <= i_hwdata[PINS-1:0];
        sleep_wake_pkg::OFF_IRQ_EN:  irq_enable <= i_hwdata[IRQS-1:0];
        sleep_wake_pkg::OFF_CONTROL: wdog_sleep_en <= i_hwdata[sleep_wake_pkg::CTL_WDOG_SLEEP];
        default: ;
      endcase
    end
  end

  // write zero to a flag bit to clear it; hardware set wins
  assign flag_clear = (wr_data && req.addr == sleep_wake_pkg::OFF_FLAGS) ?
                      ~i_hwdata[PINS-1:0] : '0;

  always_comb begin
    next_flags = (edge_change_flags & ~flag_clear)
               | (rise_hit & rise_wake_enable)
               | (fall_hit & fall_wake_enable);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      edge_change_flags <= sleep_wake_pkg::EDGE_RESET[PINS-1:0];
    end else begin
      edge_change_flags <= next_flags;
    end
  end

  assign o_change_irq_summary = |edge_change_flags;

  // ----------------------------------------------------------------------
  // wake decision and power state
  // ----------------------------------------------------------------------
  // summary flag feeds irq line 0 through its enable
  assign irq_wake = |(irq_enable
                      & (i_irq_flags | {{(IRQS-1){1'b0}}, o_change_irq_summary}));
  assign reset_wake = (i_ext_reset_pin_enable && !i_ext_reset_pin_n)
                    || (i_brownout_enable && i_brownout_reset)
                    || i_power_on_reset;
  assign wdog_wake  = i_wdog_enable && wdog_sleep_en && (state == sleep_wake_pkg::PS_SLEEP)
                    && (&o_watchdog_counter);
  assign nop_sleep   = i_power_down_exec && irq_wake && (state == sleep_wake_pkg::PS_RUN);
  assign enter_sleep = i_power_down_exec && !irq_wake && (state == sleep_wake_pkg::PS_RUN);
  assign wake_now    = (state == sleep_wake_pkg::PS_SLEEP) && (irq_wake || wdog_wake);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || reset_wake) begin
      state <= sleep_wake_pkg::PS_RUN;
    end else begin
      case (state)
        sleep_wake_pkg::PS_RUN:   if (enter_sleep) state <= sleep_wake_pkg::PS_SLEEP;
        sleep_wake_pkg::PS_SLEEP: if (wake_now) state <= sleep_wake_pkg::PS_RUN;
        default:                  state <= sleep_wake_pkg::PS_RUN;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      power_down_flag      <= sleep_wake_pkg::STATUS_RESET[sleep_wake_pkg::ST_POWER_DOWN];
      watchdog_expiry_flag <= sleep_wake_pkg::STATUS_RESET[sleep_wake_pkg::ST_WDOG_EXPIRY];
    end else if (enter_sleep) begin
      power_down_flag      <= 1'b0;
      watchdog_expiry_flag <= 1'b1;
    end else if (wdog_wake) begin
      watchdog_expiry_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------------
  assign wdog_clear = enter_sleep || wake_now || reset_wake;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || wdog_clear) begin
      o_watchdog_counter <= '0;
    end else if (nop_sleep) begin
      o_watchdog_counter <= o_watchdog_counter;
    end else if (i_wdog_enable && (state == sleep_wake_pkg::PS_RUN || wdog_sleep_en)) begin
      o_watchdog_counter <= o_watchdog_counter
                          + {{(sleep_wake_pkg::WDOG_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------------
  // outputs to core and peripherals
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prefetch_next <= 1'b0;
      o_resume        <= 1'b0;
      o_vector_irq    <= 1'b0;
      o_device_reset  <= 1'b0;
    end else begin
      o_prefetch_next <= i_power_down_exec;
      o_resume        <= wake_now;
      o_vector_irq    <= wake_now && irq_wake && i_global_irq_gate;
      o_device_reset  <= reset_wake && (state == sleep_wake_pkg::PS_SLEEP);
    end
  end

  assign o_cpu_clk_en      = (state != sleep_wake_pkg::PS_SLEEP);
  assign o_low_freq_osc_en = 1'b1;
  assign o_timer1_run      = (state == sleep_wake_pkg::PS_RUN) || i_timer1_on_slow_clk;
  assign o_adc_run         = (state == sleep_wake_pkg::PS_RUN) || i_adc_on_dedicated_osc;
  assign o_pin_hold        = (state == sleep_wake_pkg::PS_SLEEP);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_entry_flags: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    enter_sleep && !reset_wake |=> !power_down_flag && watchdog_expiry_flag)
    else $error("entry did not update status flags");
  a_entry_gates: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    enter_sleep && !reset_wake |=> !o_cpu_clk_en && o_pin_hold)
    else $error("cpu clock not gated after entry");
  a_nop_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    nop_sleep && !reset_wake |=> $stable(power_down_flag) && o_cpu_clk_en)
    else $error("no_operation sleep changed state");
  a_wake_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wake_now |=> o_watchdog_counter == '0 && o_resume)
    else $error("wake did not clear watchdog");
  a_vector_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_vector_irq |-> o_resume && $past(i_global_irq_gate))
    else $error("vector without global gate");
  a_rise_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rise_hit & rise_wake_enable) != '0 |=>
    (edge_change_flags & $past(rise_hit & rise_wake_enable)) == $past(rise_hit & rise_wake_enable))
    else $error("rising edge flag missed");
  a_fall_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (fall_hit & fall_wake_enable) != '0 |=> o_change_irq_summary &&
    (edge_change_flags & $past(fall_hit & fall_wake_enable)) == $past(fall_hit & fall_wake_enable))
    else $error("falling edge flag missed");
  a_osc_run: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_pin_hold |-> o_low_freq_osc_en && (o_timer1_run == i_timer1_on_slow_clk))
    else $error("slow oscillator or timer1 stopped");

endmodule // sleep_wake_control

// ---- test/core_model.sv ----
// core_model: cpu core and interrupt sources beside the sleep/wake controller
// assumes: one clock; bench calls the tasks, which change signals after a rising edge
module core_model (
  input  wire logic       i_clk,
  input  wire logic       i_prefetch_next,
  input  wire logic       i_resume,
  input  wire logic       i_vector_irq,
  output logic            o_power_down_exec,
  output logic            o_global_irq_gate,
  output logic [7:0]      o_irq_flags
);
  timeunit 1ns;
  timeprecision 100ps;

  int prefetches = 0;
  int resumes    = 0;
  int vectors    = 0;

  initial begin
    o_power_down_exec = 1'b0;
    o_global_irq_gate = 1'b0;
    o_irq_flags       = 8'h00;
  end

  // power-down instruction: the only way the core asks for sleep
  task automatic exec_sleep();
    @(posedge i_clk);
    o_power_down_exec <= 1'b1;
    @(posedge i_clk);
    o_power_down_exec <= 1'b0;
  endtask

  task automatic set_irq(input logic [7:0] flags, input logic gate);
    @(posedge i_clk);
    o_irq_flags       <= flags;
    o_global_irq_gate <= gate;
  endtask

  // count the core-side pulses so the bench need not catch them live
  always @(posedge i_clk) begin
    if (i_prefetch_next === 1'b1) prefetches <= prefetches + 1;
    if (i_resume === 1'b1) resumes <= resumes + 1;
    if (i_vector_irq === 1'b1) vectors <= vectors + 1;
  end
endmodule // core_model

// ---- test/sleep_wake_control_tb.sv ----
// sleep_wake_control_tb: register, pin edge, sleep entry, wake and reset scenarios
// assumes: core_model on the core side; bench is the ahb-lite master
module sleep_wake_control_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] PD = 32'h1 << sleep_wake_pkg::ST_POWER_DOWN;
  localparam logic [31:0] TO = 32'h1 << sleep_wake_pkg::ST_WDOG_EXPIRY;
  localparam logic [31:0] AS = 32'h1 << sleep_wake_pkg::ST_ASLEEP;

  logic i_clk, i_rst_n, hsel, hwrite, wd_en, ext_en, bo_en, ext_n, bo_rst, por, t1, adc;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] pins;
  logic hreadyout, hresp, pdx, gate, cpu_en, lfo, t1_run, adc_run, hold, pref, res, vec;
  logic dev_rst, summ;
  logic [7:0] irqs;
  logic [15:0] wdog;
  int fails = 0;
  int samples_checked = 0;
  int resets_seen = 0;
  int cycles = 0;

  sleep_wake_control u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_power_down_exec(pdx), .i_global_irq_gate(gate), .i_irq_flags(irqs),
    .i_timer1_on_slow_clk(t1), .i_adc_on_dedicated_osc(adc), .i_wdog_enable(wd_en),
    .i_ext_reset_pin_enable(ext_en), .i_brownout_enable(bo_en), .i_ext_reset_pin_n(ext_n),
    .i_brownout_reset(bo_rst), .i_power_on_reset(por), .i_pins(pins), .o_cpu_clk_en(cpu_en),
    .o_low_freq_osc_en(lfo), .o_timer1_run(t1_run), .o_adc_run(adc_run), .o_pin_hold(hold),
    .o_prefetch_next(pref), .o_resume(res), .o_vector_irq(vec), .o_device_reset(dev_rst),
    .o_change_irq_summary(summ), .o_watchdog_counter(wdog));

  core_model u_core (.i_clk(i_clk), .i_prefetch_next(pref), .i_resume(res),
    .i_vector_irq(vec), .o_power_down_exec(pdx), .o_global_irq_gate(gate), .o_irq_flags(irqs));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // reset pulses are short, so count them as they pass; hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (dev_rst === 1'b1) resets_seen++;
    if (cycles == 90000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one single ahb-lite transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge i_clk);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= sleep_wake_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge i_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, exp, what);
    chk(32'(hresp), 32'h0, "okay response");
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask

  task automatic set_pins(input logic [5:0] v);
    @(posedge i_clk);
    pins <= v;
    settle(8);
  endtask

  initial begin
    int r0;
    {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
    {wd_en, ext_en, bo_en, bo_rst, por, t1, adc} = '0;
    {i_rst_n, ext_n, pins} = {2'b01, 6'h02};
    do_reset();
    rd_chk(sleep_wake_pkg::OFF_RISE_EN, 32'h0, "rise enable reset");
    rd_chk(sleep_wake_pkg::OFF_FALL_EN, 32'h0, "fall enable reset");
    rd_chk(sleep_wake_pkg::OFF_FLAGS, 32'h0, "flags reset");
    rd_chk(sleep_wake_pkg::OFF_STATUS, PD | TO, "status reset");
    rd_chk(12'h020, 32'h0, "unmapped read");
    wr(sleep_wake_pkg::OFF_RISE_EN, 32'hFF);
    rd_chk(sleep_wake_pkg::OFF_RISE_EN, 32'h3F, "rise enable top bits");
    wr(sleep_wake_pkg::OFF_FALL_EN, 32'hFF);
    rd_chk(sleep_wake_pkg::OFF_FALL_EN, 32'h3F, "fall enable top bits");
    wr(sleep_wake_pkg::OFF_RISE_EN, 32'h01);
    wr(sleep_wake_pkg::OFF_FALL_EN, 32'h02);
    set_pins(6'h06);
    rd_chk(sleep_wake_pkg::OFF_FLAGS, 32'h0, "rise on disabled pin");
    chk(32'(summ), 32'h0, "summary idle");
    set_pins(6'h07);
    rd_chk(sleep_wake_pkg::OFF_FLAGS, 32'h01, "rise on pin0");
    chk(32'(summ), 32'h1, "summary set");
    set_pins(6'h05);
    rd_chk(sleep_wake_pkg::OFF_FLAGS, 32'h03, "fall on pin1");
    set_pins(6'h06);
    rd_chk(sleep_wake_pkg::OFF_FLAGS, 32'h03, "sticky flags");
    wr(sleep_wake_pkg::OFF_FLAGS, 32'h02);
    rd_chk(sleep_wake_pkg::OFF_FLAGS, 32'h02, "clear bit0 only");
    wr(sleep_wake_pkg::OFF_FLAGS, 32'h00);
    settle(1);
    chk(32'(summ), 32'h0, "summary cleared");
    // enabled irq already pending: instruction does nothing
    wr(sleep_wake_pkg::OFF_IRQ_EN, 32'h02);
    u_core.set_irq(8'h02, 1'b0);
    u_core.exec_sleep();
    settle(2);
    chk(32'(cpu_en), 32'h1, "no sleep with pending irq");
    rd_chk(sleep_wake_pkg::OFF_STATUS, PD | TO, "status kept");
    u_core.set_irq(8'h00, 1'b0);
    {t1, adc} <= 2'b11;
    settle(3);
    chk(32'(cpu_en), 32'h1, "running without instruction");
    r0 = u_core.prefetches;
    u_core.exec_sleep();
    #1;
    chk(32'(cpu_en), 32'h0, "cpu clock stopped");
    chk(32'(pref), 32'h1, "prefetch pulse");
    chk(32'(wdog), 32'h0, "watchdog cleared on entry");
    chk({29'h0, lfo, t1_run, adc_run}, 32'h7, "slow osc timer1 adc run");
    chk(32'(hold), 32'h1, "pins held");
    rd_chk(sleep_wake_pkg::OFF_STATUS, TO | AS, "status asleep");
    chk(u_core.prefetches - r0, 32'h1, "one prefetch");
    u_core.set_irq(8'h04, 1'b0);
    ext_n <= 1'b0;
    settle(5);
    chk(32'(cpu_en), 32'h0, "disabled irq stays asleep");
    chk(resets_seen, 0, "disabled reset pin");
    ext_n <= 1'b1;
    r0 = u_core.resumes;
    u_core.set_irq(8'h06, 1'b0);
    settle(3);
    chk(32'(cpu_en), 32'h1, "irq wake");
    chk(u_core.resumes - r0, 32'h1, "resume pulse");
    chk(u_core.vectors, 32'h0, "no vector with gate off");
    chk(32'(wdog), 32'h0, "watchdog cleared on wake");
    rd_chk(sleep_wake_pkg::OFF_STATUS, TO, "status after wake");
    u_core.set_irq(8'h00, 1'b1);
    u_core.exec_sleep();
    u_core.set_irq(8'h02, 1'b1);
    settle(3);
    chk(u_core.vectors, 32'h1, "vector with gate on");
    u_core.set_irq(8'h00, 1'b0);
    wr(sleep_wake_pkg::OFF_IRQ_EN, 32'h01);
    u_core.exec_sleep();
    set_pins(6'h07);
    chk(32'(cpu_en), 32'h1, "pin change wake");
    wr(sleep_wake_pkg::OFF_FLAGS, 32'h00);
    wr(sleep_wake_pkg::OFF_CONTROL, 32'h01);
    wd_en <= 1'b1;
    r0 = u_core.resumes;
    u_core.exec_sleep();
    #1;
    chk(32'(wdog), 32'h0, "watchdog cleared on sleep entry");
    settle(10);
    chk(32'(wdog), 32'h0000_000A, "watchdog counts asleep");
    for (int i = 0; i < 70000 && res !== 1'b1; i++) begin
      @(posedge i_clk);
      #1;
    end
    chk(32'(wdog), 32'h0, "watchdog cleared after expiry");
    wd_en <= 1'b0;
    settle(1);
    chk(u_core.resumes - r0, 32'h1, "watchdog wake");
    rd_chk(sleep_wake_pkg::OFF_STATUS, 32'h0, "expiry clears flag");
    {ext_en, bo_en} <= 2'b11;
    for (int k = 0; k < 3; k++) begin
      u_core.exec_sleep();
      @(posedge i_clk);
      {ext_n, bo_rst, por} <= {k != 0, k == 1, k == 2};
      settle(3);
      chk(resets_seen, k + 1, "reset source wakes by reset");
      {ext_n, bo_rst, por} <= 3'b100;
      do_reset();
    end
    finish_test();
  end
endmodule // sleep_wake_control_tb
